// *** rtl/ofr_pkg.sv ***
// constants for the output fault retry and output voltage threshold block
// assumes one 10 MHz system clock and a command port driven by management logic
//
// Functional notes
// - retry codes 011 to 110 give exactly 3 to 6 restart attempts after a fault shutdown.
// - when all permitted attempts fail the output is disabled and stays off until cleared.
// - retry code 111 retries forever until off command, bias loss or another fault.
// - attempt starts are spaced by the decoded multiplier times the delay time unit, or by two cycles when that product is one cycle.
// - the same multiplier times the unit sets how long operation continues after a fault.
// - multiplier codes 0 to 7 decode to 1, 2, 4, 8, 16, 32, 64 and 128 time units.
// - the length of one time unit comes from the separate time unit setting, not the byte.
// - command 0x42 is a read/write 16-bit output high warning threshold.
// - command 0x43 is a read/write 16-bit output low warning threshold.
// - command 0x44 is a read/write 16-bit output low fault threshold.
// - the retry count is in bits 5:3 and code 000 means no restart, output stays off.
package ofr_pkg;
  localparam logic [7:0] CMD_HIGH_WARN = 8'h42;
  localparam logic [7:0] CMD_LOW_WARN = 8'h43;
  localparam logic [7:0] CMD_LOW_FAULT = 8'h44;
  localparam int RETRY_LSB = 3;
  localparam int RETRY_MSB = 5;
  localparam int DELAY_LSB = 0;
  localparam int DELAY_MSB = 2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [15:0] HIGH_WARN_RESET = 16'hffff;
  localparam logic [15:0] LOW_WARN_RESET = 16'h0000;
  localparam logic [15:0] LOW_FAULT_RESET = 16'h0000;
  localparam logic [15:0] UNIT_CYCLES_RESET = 16'h0001;
  typedef enum logic [4:0] {
    OFR_RUN = 5'h01,
    OFR_CONTINUE = 5'h02,
    OFR_WAIT = 5'h04,
    OFR_ATTEMPT = 5'h08,
    OFR_LATCHED = 5'h10
  } ofr_state_t;
endpackage

// *** rtl/ofr_unit_tick.sv ***
// delay time unit divider: one-cycle pulse every unit_cycles clocks
// assumes unit_cycles is held steady while a delay is running
module ofr_unit_tick #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [WIDTH-1:0] unit_cycles,
  output logic tick
);
  initial begin
    if (WIDTH < 1 || WIDTH > 31) $error("ofr_unit_tick: WIDTH out of range");
  end
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  wire logic [WIDTH-1:0] unit_safe = (unit_cycles == '0) ? WIDTH'(1) : unit_cycles;
  wire logic at_end = (count_reg >= unit_safe - WIDTH'(1));
  // a zero setting is treated as one cycle so the delay never stalls
  assign count_next = (restart || at_end) ? '0 : count_reg + WIDTH'(1);
  // not gated by restart: the sequencer's restart decision is made from this tick
  assign tick = at_end;
  always_ff @(posedge sys_clk) begin
    if (rst) count_reg <= '0;
    else count_reg <= count_next;
  end
endmodule

// *** rtl/ofr_top.sv ***
// output fault retry sequencer and output voltage threshold registers
// assumes fault, off and clear inputs come from logic on sys_clk; no pin is sampled here
module ofr_top #(
  parameter int UNIT_WIDTH = 16,
  parameter int VWIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic cmd_unmapped,
  input wire logic [7:0] fault_response,
  input wire logic delayed_action,
  input wire logic [UNIT_WIDTH-1:0] time_unit_cycles,
  input wire logic fault_present,
  input wire logic clear_fault,
  input wire logic off_command,
  input wire logic bias_lost,
  input wire logic other_fault_shutdown,
  input wire logic [VWIDTH-1:0] vout_measured,
  output logic output_enable,
  output logic output_latched_off,
  output logic retry_active,
  output logic high_warning,
  output logic low_warning,
  output logic low_fault
);
  initial begin
    if (VWIDTH != 16) $error("ofr_top: thresholds are 16-bit words");
  end

  function automatic logic [8:0] units_of(input logic [2:0] code);
    units_of = 9'h001 << code;
  endfunction

  ofr_pkg::ofr_state_t state_reg, state_next;
  logic [15:0] high_warn_reg;
  logic [15:0] low_warn_reg;
  logic [15:0] low_fault_reg;
  logic [8:0] units_left_reg, units_left_next;
  logic [2:0] tries_left_reg, tries_left_next;
  logic out_en_reg, out_en_next;
  logic [15:0] rdata_reg;
  logic rvalid_reg;
  logic unmapped_reg;
  logic hw_reg, lw_reg, lf_reg;
  logic off_seen_reg;

  wire logic [2:0] retry_code = fault_response[ofr_pkg::RETRY_MSB:ofr_pkg::RETRY_LSB];
  wire logic [2:0] delay_code = fault_response[ofr_pkg::DELAY_MSB:ofr_pkg::DELAY_LSB];
  wire logic [8:0] delay_units = units_of(delay_code);
  wire logic unit_tick;
  wire logic delay_start;
  wire logic delay_done = unit_tick && (units_left_reg == 9'h001);
  wire logic forever_retry = (retry_code == ofr_pkg::RETRY_FOREVER);
  wire logic stop_now = off_command || bias_lost;

  wire logic sel_hw = (cmd_code == ofr_pkg::CMD_HIGH_WARN);
  wire logic sel_lw = (cmd_code == ofr_pkg::CMD_LOW_WARN);
  wire logic sel_lf = (cmd_code == ofr_pkg::CMD_LOW_FAULT);
  wire logic sel_any = sel_hw || sel_lw || sel_lf;
  wire logic [15:0] rd_mux = sel_hw ? high_warn_reg :
                             sel_lw ? low_warn_reg :
                             sel_lf ? low_fault_reg : 16'h0000;

  ofr_unit_tick #(.WIDTH(UNIT_WIDTH)) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(delay_start),
    .unit_cycles(time_unit_cycles),
    .tick(unit_tick)
  );

  // next-state of the retry sequencer
  always_comb begin
    state_next = state_reg;
    out_en_next = out_en_reg;
    tries_left_next = tries_left_reg;
    case (state_reg)
      ofr_pkg::OFR_RUN: begin
        out_en_next = 1'b1;
        if (fault_present) begin
          if (delayed_action) begin
            state_next = ofr_pkg::OFR_CONTINUE;
          end else if (retry_code == ofr_pkg::RETRY_NONE) begin
            state_next = ofr_pkg::OFR_LATCHED;
            out_en_next = 1'b0;
          end else begin
            state_next = ofr_pkg::OFR_WAIT;
            out_en_next = 1'b0;
            tries_left_next = retry_code;
          end
        end
      end
      ofr_pkg::OFR_CONTINUE: begin
        if (delay_done) begin
          if (!fault_present) begin
            state_next = ofr_pkg::OFR_RUN;
          end else if (retry_code == ofr_pkg::RETRY_NONE) begin
            state_next = ofr_pkg::OFR_LATCHED;
            out_en_next = 1'b0;
          end else begin
            state_next = ofr_pkg::OFR_WAIT;
            out_en_next = 1'b0;
            tries_left_next = retry_code;
          end
        end
      end
      ofr_pkg::OFR_WAIT: begin
        if (delay_done) begin
          if (tries_left_reg == 3'h0) begin
            state_next = ofr_pkg::OFR_LATCHED;
          end else begin
            state_next = ofr_pkg::OFR_ATTEMPT;
            out_en_next = 1'b1;
            if (!forever_retry) tries_left_next = tries_left_reg - 3'h1;
          end
        end
      end
      ofr_pkg::OFR_ATTEMPT: begin
        // an attempt succeeds when it survives one full spacing period
        // a fault seen as the spacing ends wins, so a one-cycle spacing stretches to two
        if (fault_present) begin
          state_next = ofr_pkg::OFR_WAIT;
          out_en_next = 1'b0;
        end else if (delay_done) begin
          state_next = ofr_pkg::OFR_RUN;
        end
      end
      ofr_pkg::OFR_LATCHED: begin
        out_en_next = 1'b0;
        if (clear_fault) state_next = ofr_pkg::OFR_RUN;
      end
      default: begin
        state_next = ofr_pkg::OFR_LATCHED;
        out_en_next = 1'b0;
      end
    endcase
    if (other_fault_shutdown) begin
      state_next = ofr_pkg::OFR_LATCHED;
      out_en_next = 1'b0;
    end
    // off command or bias loss holds the output off; releasing it acts as an off-on clear
    if (stop_now) begin
      state_next = ofr_pkg::OFR_LATCHED;
      out_en_next = 1'b0;
    end else if (!other_fault_shutdown && state_reg == ofr_pkg::OFR_LATCHED && off_seen_reg) begin
      state_next = ofr_pkg::OFR_RUN;
    end
  end

  // the delay restarts on entering a timed state; a wait entered from a failed attempt reuses the attempt's delay
  assign delay_start = (state_next != state_reg) &&
                       (state_next == ofr_pkg::OFR_CONTINUE ||
                        state_next == ofr_pkg::OFR_WAIT && state_reg != ofr_pkg::OFR_ATTEMPT ||
                        state_next == ofr_pkg::OFR_ATTEMPT);
  assign units_left_next = delay_start ? delay_units :
                           (unit_tick && units_left_reg > 9'h001) ? units_left_reg - 9'h001 :
                           (unit_tick && units_left_reg == 9'h001) ? delay_units :
                           units_left_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ofr_pkg::OFR_RUN;
      out_en_reg <= 1'b0;
      tries_left_reg <= 3'h0;
      units_left_reg <= 9'h001;
      off_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      out_en_reg <= out_en_next;
      tries_left_reg <= tries_left_next;
      units_left_reg <= units_left_next;
      off_seen_reg <= stop_now;
    end
  end

  // threshold registers on the command port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_warn_reg <= ofr_pkg::HIGH_WARN_RESET;
      low_warn_reg <= ofr_pkg::LOW_WARN_RESET;
      low_fault_reg <= ofr_pkg::LOW_FAULT_RESET;
    end else if (cmd_wr) begin
      if (sel_hw) high_warn_reg <= cmd_wdata;
      if (sel_lw) low_warn_reg <= cmd_wdata;
      if (sel_lf) low_fault_reg <= cmd_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      unmapped_reg <= 1'b0;
    end else begin
      rvalid_reg <= cmd_rd;
      unmapped_reg <= (cmd_rd || cmd_wr) && !sel_any;
      if (cmd_rd) rdata_reg <= rd_mux;
    end
  end

  // unsigned compare; flags are levels that follow the measurement
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hw_reg <= 1'b0;
      lw_reg <= 1'b0;
      lf_reg <= 1'b0;
    end else begin
      hw_reg <= vout_measured > high_warn_reg;
      lw_reg <= vout_measured < low_warn_reg;
      lf_reg <= vout_measured < low_fault_reg;
    end
  end

  logic latched_reg;
  logic retry_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latched_reg <= 1'b0;
      retry_reg <= 1'b0;
    end else begin
      latched_reg <= (state_next == ofr_pkg::OFR_LATCHED);
      retry_reg <= (state_next == ofr_pkg::OFR_WAIT) || (state_next == ofr_pkg::OFR_ATTEMPT);
    end
  end

  assign output_enable = out_en_reg;
  assign output_latched_off = latched_reg;
  assign retry_active = retry_reg;
  assign cmd_rdata = rdata_reg;
  assign cmd_rvalid = rvalid_reg;
  assign cmd_unmapped = unmapped_reg;
  assign high_warning = hw_reg;
  assign low_warning = lw_reg;
  assign low_fault = lf_reg;
endmodule

// *** test/ofr_checker.sv ***
// assertions on ofr_top ports: command port answers, shutdown and retry spacing
// assumes it is bound into every ofr_top; all signals on sys_clk
module ofr_checker #(
  parameter int UNIT_WIDTH = 16,
  parameter int VWIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_rvalid,
  input wire logic cmd_unmapped,
  input wire logic [7:0] fault_response,
  input wire logic delayed_action,
  input wire logic [UNIT_WIDTH-1:0] time_unit_cycles,
  input wire logic fault_present,
  input wire logic off_command,
  input wire logic bias_lost,
  input wire logic other_fault_shutdown,
  input wire logic output_enable,
  input wire logic output_latched_off,
  input wire logic retry_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic stop_req = off_command || bias_lost || other_fault_shutdown;
  rd_answer_a: assert property (cmd_rd |=> cmd_rvalid)
    else $error("read not answered");
  unmapped_flag_a: assert property ((cmd_rd || cmd_wr) && !(cmd_code inside {[8'h42:8'h44]})
    |=> cmd_unmapped) else $error("unmapped access not flagged");
  write_read_a: assert property (cmd_wr && cmd_code == 8'h42 ##1 cmd_rd && cmd_code == 8'h42
    |=> cmd_rdata == $past(cmd_wdata, 2)) else $error("written word not read back");
  fault_off_a: assert property (output_enable && fault_present && !delayed_action && !stop_req
    |=> !output_enable) else $error("output stayed on after fault");
  no_retry_a: assert property (output_enable && !retry_active && fault_present && !stop_req
    && !delayed_action && fault_response[5:3] == 3'h0 |-> ##[1:2] output_latched_off)
    else $error("retry code zero did not latch off");
  stop_off_a: assert property (stop_req |=> !output_enable)
    else $error("output on while commanded off");
  latched_quiet_a: assert property (output_latched_off |-> !output_enable && !retry_active)
    else $error("latched state not quiet");
  retry_gap_a: assert property ($rose(retry_active) && !output_enable && !delayed_action
    && time_unit_cycles == 16'h0001 && fault_response[2:0] == 3'h2
    |-> !output_enable [*4] ##1 output_enable) else $error("restart spacing wrong");
  cover property (cmd_rvalid);
  cover property ($rose(output_latched_off) && $past(retry_active));
  cover property (cmd_unmapped);
endmodule

bind ofr_top ofr_checker #(.UNIT_WIDTH(UNIT_WIDTH), .VWIDTH(VWIDTH)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
  .cmd_unmapped(cmd_unmapped), .fault_response(fault_response),
  .delayed_action(delayed_action), .time_unit_cycles(time_unit_cycles),
  .fault_present(fault_present), .off_command(off_command), .bias_lost(bias_lost),
  .other_fault_shutdown(other_fault_shutdown), .output_enable(output_enable),
  .output_latched_off(output_latched_off), .retry_active(retry_active));

// *** test/ofr_host_model.sv ***
// host model: writes and reads whole configuration words on the command port
// assumes the caller stands just after a rising edge of sys_clk
module ofr_host_model (
  input wire logic sys_clk,
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // one access per edge, so back-to-back calls give back-to-back strobes
  task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data);
    cmd_code <= code;
    cmd_wr <= wr;
    cmd_rd <= !wr;
    cmd_wdata <= wr ? data : ~cmd_wdata;
    @(posedge sys_clk);
  endtask
  // released lines are scrambled so stale values cannot pass for good ones
  task automatic idle();
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    cmd_code <= ~cmd_code;
    cmd_wdata <= ~cmd_wdata;
    @(posedge sys_clk);
  endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench for ofr_top: registers, flags, retry counts and spacing
// assumes the host model in ofr_host_model.sv and the bound checker
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst = 1'b1, delayed_action = 1'b0, fault_present = 1'b0;
  logic clear_fault = 1'b0, cmd_wr, cmd_rd, cmd_rvalid, cmd_unmapped, output_enable;
  logic output_latched_off, retry_active, high_warning, low_warning, low_fault, prev;
  logic [2:0] ovr = 3'h0;
  logic [7:0] cmd_code, fault_response = 8'h00;
  logic [15:0] cmd_wdata, cmd_rdata, w, time_unit_cycles = 16'h0001, vout_measured = 16'h0000;
  logic [7:0] codes [3] = '{8'h42, 8'h43, 8'h44};
  logic [15:0] vals [3] = '{ofr_pkg::HIGH_WARN_RESET, ofr_pkg::LOW_WARN_RESET,
    ofr_pkg::LOW_FAULT_RESET};
  logic [15:0] expq [$];
  int fail_count = 0, checks = 0, rises, last, d;
  always #50 sys_clk = ~sys_clk;
  ofr_host_model host_u (.sys_clk(sys_clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata));
  ofr_top dut_u (.sys_clk(sys_clk), .rst(rst), .cmd_code(cmd_code), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .cmd_unmapped(cmd_unmapped), .fault_response(fault_response),
    .delayed_action(delayed_action), .time_unit_cycles(time_unit_cycles),
    .fault_present(fault_present), .clear_fault(clear_fault), .off_command(ovr[0]),
    .bias_lost(ovr[1]), .other_fault_shutdown(ovr[2]), .vout_measured(vout_measured),
    .output_enable(output_enable), .output_latched_off(output_latched_off),
    .retry_active(retry_active), .high_warning(high_warning), .low_warning(low_warning),
    .low_fault(low_fault));
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(logic [7:0] code, logic [15:0] exp);
    expq.push_back(exp);
    host_u.access(1'b0, code, 16'h0000);
  endtask
  always @(negedge sys_clk) begin
    if (cmd_rvalid === 1'b1) begin
      if (expq.size() == 0) chk("read count", 16'h0000, 16'h0001);
      else chk("read data", expq.pop_front(), cmd_rdata);
    end
  end
  // counts attempt starts and checks the spacing between them
  task automatic run_out(int limit);
    rises = 0;
    prev = 1'b1;
    for (int n = 0; n < limit && output_latched_off !== 1'b1; n++) begin
      @(negedge sys_clk);
      if (output_enable === 1'b1 && prev !== 1'b1) begin
        // a one-cycle spacing needs an off cycle between attempts, so it shows as two
        if (rises > 0) chk("attempt spacing", 16'((d < 2) ? 2 : d), 16'(n - last));
        rises++;
        last = n;
      end
      prev = output_enable;
    end
  endtask
  task automatic settle(logic on);
    @(posedge sys_clk);
    tick(4);
    @(negedge sys_clk);
    chk("output enable", 16'(on), 16'(output_enable));
    @(posedge sys_clk);
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    fail_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(54555));
    tick(16);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++) rd(codes[i], vals[i]);
    for (int i = 0; i < 3; i++) begin
      w = 16'($urandom);
      vals[i] = w;
      host_u.access(1'b1, codes[i], w);
      rd(codes[i], w);
    end
    host_u.access(1'b1, 8'h45, 16'h1234);
    rd(8'h45, 16'h0000);
    host_u.idle();
    $display("test registers done");
    for (int j = 0; j < 8; j++) begin
      vout_measured <= (j == 0) ? vals[0] : 16'($urandom);
      tick(3);
      @(negedge sys_clk);
      chk("high warning", 16'(vout_measured > vals[0]), 16'(high_warning));
      chk("low warning", 16'(vout_measured < vals[1]), 16'(low_warning));
      chk("low fault", 16'(vout_measured < vals[2]), 16'(low_fault));
      @(posedge sys_clk);
    end
    $display("test flags done");
    for (int c = 0; c < 7; c++) begin
      d = (1 << (c % 3)) * (1 + c % 2);
      fault_response <= {2'b00, 3'(c), 3'(c % 3)};
      time_unit_cycles <= 16'(1 + c % 2);
      tick(3);
      fault_present <= 1'b1;
      run_out(600);
      chk("attempts", 16'(c), 16'(rises));
      chk("latched", 16'h0001, 16'(output_latched_off));
      @(posedge sys_clk);
      fault_present <= 1'b0;
      clear_fault <= 1'b1;
      @(posedge sys_clk);
      clear_fault <= 1'b0;
      settle(1'b1);
    end
    $display("test retry counts done");
    d = 1;
    for (int k = 0; k < 3; k++) begin
      fault_response <= {2'b00, ofr_pkg::RETRY_FOREVER, 3'h0};
      time_unit_cycles <= 16'h0001;
      fault_present <= 1'b1;
      run_out(200);
      chk("endless retry", 16'h0001, 16'(rises > 20 && output_latched_off === 1'b0));
      @(posedge sys_clk);
      ovr <= 3'(1 << k);
      fault_present <= 1'b0;
      settle(1'b0);
      ovr <= 3'h0;
      clear_fault <= (k == 2);
      settle(1'b1);
      clear_fault <= 1'b0;
    end
    $display("test endless retry done");
    d = 8;
    fault_response <= 8'h02;
    time_unit_cycles <= 16'h0002;
    delayed_action <= 1'b1;
    fault_present <= 1'b1;
    last = 0;
    while (output_enable === 1'b1 && last < 50) begin
      @(negedge sys_clk);
      last++;
    end
    // one edge to take the fault, one negedge to see the enable fall
    chk("continue time", 16'(d + 2), 16'(last));
    @(posedge sys_clk);
    fault_present <= 1'b0;
    delayed_action <= 1'b0;
    clear_fault <= 1'b1;
    settle(1'b1);
    $display("test delayed action done");
    wrap_up();
  end
endmodule
